// File: shared/tds_pkg.sv
// Purpose: Shared constants, types and register map for the dissolved-solids sequencer.
// Assumes: APB with 32-bit data, pclk at 25 MHz.
// Notes: All offsets are byte addresses of aligned words.
package tds_pkg;
   // Clock and time base
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned CLK_NS = 40;
   localparam int unsigned PULSE_US = 300;
   localparam int unsigned CYCLE_MS = 3;
   localparam int unsigned PULSES_PER_S = 10;
   localparam int unsigned PULSE_CYC = (PULSE_US * 1000) / CLK_NS;
   localparam int unsigned MCYCLE_CYC = (CYCLE_MS * 1_000_000) / CLK_NS;
   localparam int unsigned SLOT_CYC = CLK_HZ / PULSES_PER_S;
   localparam int unsigned SEC_CYC = CLK_HZ;
   // Polarization sampling at the start of a cycle, probe current sampled at pulse end
   localparam int unsigned POL_CYC = 4;
   // Sequencer timing in seconds
   localparam int unsigned SETTLE_S = 5;
   localparam int unsigned MEASURE_S = 5;
   localparam int unsigned CAL_WAIT_S = 60;
   localparam logic [8:0] BDT_MIN = 9'd5;
   localparam logic [8:0] BDT_MAX = 9'd300;
   localparam logic [8:0] STI_MIN = 9'd60;
   localparam logic [8:0] STI_MAX = 9'd300;
   localparam logic [8:0] DST_MIN = 9'd3;
   localparam logic [8:0] DST_MAX = 9'd10;
   // Conversion: ppm = uS * mult / 1024; 0.7 -> 717, +/-7% -> 667..767
   localparam logic [9:0] MULT_NOM = 10'd717;
   localparam logic [9:0] MULT_MIN = 10'd667;
   localparam logic [9:0] MULT_MAX = 10'd767;
   // Temperature slope: 2% per degree, in 1/1024 units per degree
   localparam logic [7:0] TSLOPE = 8'd20;
   // Register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TARGET = 8'h04;
   localparam logic [7:0] OFS_BDT = 8'h08;
   localparam logic [7:0] OFS_STI = 8'h0C;
   localparam logic [7:0] OFS_DST = 8'h10;
   localparam logic [7:0] OFS_MULT = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_READING = 8'h1C;
   localparam logic [7:0] OFS_REFCOND = 8'h20;
   localparam logic [7:0] OFS_REFPPM = 8'h24;
   localparam logic [7:0] OFS_CALPPM = 8'h28;
   // Reset values
   localparam logic [15:0] TARGET_RST = 16'h08FC;
   localparam logic [8:0] BDT_RST = 9'd50;
   localparam logic [8:0] STI_RST = 9'd120;
   localparam logic [8:0] DST_RST = 9'd5;
   // CTRL bits
   localparam int unsigned CTRL_EN = 0;
   localparam int unsigned CTRL_CAL = 1;
   localparam int unsigned CTRL_RUN = 2;
   localparam int unsigned CTRL_AUTO = 3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_BLOW = 3'b001,
      ST_SETTLE = 3'b011,
      ST_MEAS = 3'b010,
      ST_WAIT = 3'b110,
      ST_SAMPLE = 3'b111,
      ST_CALHOLD = 3'b101
   } seq_state_t;

   // One probe reading handed from front end to sequencer
   typedef struct packed {
      logic valid;
      logic [15:0] ppm;
      logic [15:0] cond;
   } sample_t;

   // Sensor and plant inputs
   typedef struct packed {
      logic [15:0] current_ua;
      logic signed [15:0] pol_ua;
      logic signed [11:0] temp_c;
   } probe_in_t;
endpackage

// File: src/tds_frontend.sv
// Purpose: Probe excitation, polarization-corrected conductivity and ppm conversion.
// Assumes: Probe ADC words are synchronous to pclk.
// Notes: Emits one sample per excitation pulse, ten per second.
`timescale 1ns/1ns
module tds_frontend
   import tds_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Probe
   input wire probe_in_t probe,
   input wire logic probe_alive,
   output logic excite,
   // Calibration point and multiplier
   input wire logic signed [11:0] cal_temp,
   input wire logic [9:0] mult,
   // Result
   output sample_t sample
);
   logic [24:0] slot_cnt;
   logic signed [15:0] pol;
   logic [31:0] cond_raw;
   logic signed [31:0] dt;
   logic signed [47:0] cond_tc;
   logic [15:0] cond_c;
   logic [25:0] ppm_w;
   wire slot_start = (slot_cnt == 25'd0);
   wire pulse_on = (slot_cnt < 25'(PULSE_CYC));
   wire pol_take = (slot_cnt == 25'(POL_CYC - 1));
   wire meas_take = (slot_cnt == 25'(PULSE_CYC - 1));

   // Ten 300 us pulses per second, each at the start of a 100 ms slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_cnt <= '0;
         excite <= 1'b0;
      end else begin
         slot_cnt <= (slot_cnt == 25'(SLOT_CYC - 1)) ? '0 : slot_cnt + 25'd1;
         excite <= pulse_on;
      end
   end

   // Polarization sampled at cycle start, before excitation builds up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pol <= '0;
      end else if (pol_take) begin
         pol <= probe.pol_ua;
      end
   end

   // uS = mA / 0.5 V = 2 * mA; current in uA so uS*1000 scale kept as 2*uA/1000
   always_comb begin
      cond_raw = 32'(signed'(17'({1'b0, probe.current_ua})) - 17'(pol));
      if (cond_raw[31]) begin
         cond_raw = '0;
      end
      cond_raw = (cond_raw << 1) / 32'd1000;
      dt = 32'(probe.temp_c) - 32'(cal_temp);
      // 2% per degree, added for a rise, subtracted for a fall
      cond_tc = 48'(signed'({1'b0, cond_raw})) * (48'sd1024 + 48'(dt) * 48'(TSLOPE));
      cond_tc = cond_tc >>> 10;
      cond_c = (cond_tc < 0) ? 16'h0000 : (cond_tc > 48'sd65535) ? 16'hFFFF : 16'(cond_tc);
      ppm_w = (26'(cond_c) * 26'(mult)) >> 10;
   end

   // Result register, one per pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample <= '0;
      end else begin
         sample.valid <= meas_take && probe_alive;
         if (meas_take) begin
            sample.cond <= cond_c;
            sample.ppm <= (ppm_w > 26'd65535) ? 16'hFFFF : 16'(ppm_w);
         end
      end
   end
   wire unused_start = slot_start;
endmodule // tds_frontend

// File: src/tds_blowdown_sequencer.sv
// Purpose: Dissolved-solids averaging and top blowdown sequencing with APB registers.
// Assumes: pclk at 25 MHz; plant status pins are asynchronous.
// Notes: Zero-wait APB slave; unmapped reads give zero and pslverr.
// Function
// - Excite probe with ten 300 us pulses each second.
// - Measurement cycle lasts 3 ms; ten cycles per second. The code's cycle is the whole 100 ms pulse slot.
// - Sample polarization at each cycle start and correct that cycle.
// - Conductivity in uS is probe milliamps divided by 0.5 V.
// - Correct conductivity by 2 percent per degree from calibration.
// - Ppm is conductivity times 0.7, adjustable by 7 percent.
// - Each second average ten samples by summing and dividing by ten.
// - Reported reading is mean of last ten one-second averages.
// - Above target, open blowdown valve for 5 to 300 seconds.
// - After blowdown wait a fixed 5 second settlement.
// - After settlement run a 5 second measurement phase.
// - Still above target after measurement, blow down again.
// - Below target, sample every 60 to 300 seconds.
// - Each periodic sample lasts 3 to 10 seconds.
// - Periodic sample above target restarts blowdown.
// - Calibrate key runs one sequence and stores reference conductivity.
// - User calibration relates entered ppm to stored reference; run completes.
// - Automatic calibration: one minute wait, then run computes reference ppm.
// - Suspend blowdown when burner off, pressure low or probe silent; a calibration sequence is not suspended.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
module tds_blowdown_sequencer
   import tds_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = SEC_CYC
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Probe and plant
   input wire probe_in_t probe,
   input wire logic probe_alive,
   input wire logic burner_firing,
   input wire logic pressure_ok,
   output logic excite,
   output logic valve_open
);
   // Registers
   logic [3:0] ctrl;
   logic [15:0] target;
   logic [8:0] bdt;
   logic [8:0] sti;
   logic [8:0] dst;
   logic [9:0] mult;
   logic [15:0] ref_cond;
   logic signed [11:0] ref_temp;
   logic [15:0] ref_ppm;
   logic [15:0] cal_ppm;
   logic cal_done;
   logic [15:0] reading;
   // Sequencer
   seq_state_t state;
   seq_state_t next_state;
   logic [8:0] sec_left;
   logic [24:0] tick_cnt;
   logic sec_tick;
   logic [1:0] cal_phase;
   // Averaging
   logic [19:0] sec_sum;
   logic [3:0] sec_n;
   logic [15:0] hist [10];
   logic [3:0] hist_ptr;
   logic [19:0] hist_sum;
   logic hist_full;
   // Synchronised plant pins
   logic [2:0] burn_s;
   logic [2:0] press_s;
   logic burn_ok;
   logic press_ok;
   sample_t smp;

   // Probe front end
   tds_frontend u_front (
      .pclk(pclk),
      .presetn(presetn),
      .probe(probe),
      .probe_alive(probe_alive),
      .excite(excite),
      .cal_temp(ref_temp),
      .mult(mult),
      .sample(smp)
   );

   // APB decode
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire hit = (paddr <= OFS_CALPPM) && (paddr[1:0] == 2'b00);
   wire cal_key = wr && (paddr == OFS_CTRL) && pwdata[CTRL_CAL];
   wire run_key = wr && (paddr == OFS_CTRL) && pwdata[CTRL_RUN];
   wire [8:0] w9 = pwdata[8:0];
   assign pready = 1'b1;
   assign pslverr = acc && !hit;

   // Range limits on configuration writes
   wire [8:0] bdt_w = (w9 < BDT_MIN) ? BDT_MIN : (w9 > BDT_MAX) ? BDT_MAX : w9;
   wire [8:0] sti_w = (w9 < STI_MIN) ? STI_MIN : (w9 > STI_MAX) ? STI_MAX : w9;
   wire [8:0] dst_w = (w9 < DST_MIN) ? DST_MIN : (w9 > DST_MAX) ? DST_MAX : w9;
   wire [9:0] w10 = pwdata[9:0];
   wire [9:0] mult_w = (w10 < MULT_MIN) ? MULT_MIN : (w10 > MULT_MAX) ? MULT_MAX : w10;

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= '0;
         target <= TARGET_RST;
         bdt <= BDT_RST;
         sti <= STI_RST;
         dst <= DST_RST;
         mult <= MULT_NOM;
         cal_ppm <= '0;
      end else if (wr) begin
         case (paddr)
            OFS_CTRL: ctrl <= {pwdata[CTRL_AUTO], 2'b00, pwdata[CTRL_EN]};
            OFS_TARGET: target <= pwdata[15:0];
            OFS_BDT: bdt <= bdt_w;
            OFS_STI: sti <= sti_w;
            OFS_DST: dst <= dst_w;
            OFS_MULT: mult <= mult_w;
            OFS_CALPPM: cal_ppm <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Read mux
   always_comb begin
      prdata = '0;
      if (acc && !pwrite) begin
         case (paddr)
            OFS_CTRL: prdata = 32'(ctrl);
            OFS_TARGET: prdata = 32'(target);
            OFS_BDT: prdata = 32'(bdt);
            OFS_STI: prdata = 32'(sti);
            OFS_DST: prdata = 32'(dst);
            OFS_MULT: prdata = 32'(mult);
            OFS_STATUS: prdata = {18'h0_0000, sec_left, cal_done, valve_open, 3'(state)};
            OFS_READING: prdata = 32'(reading);
            OFS_REFCOND: prdata = 32'(ref_cond);
            OFS_REFPPM: prdata = 32'(ref_ppm);
            OFS_CALPPM: prdata = 32'(cal_ppm);
            default: prdata = '0;
         endcase
      end
   end

   // Plant pins: three stages, change once second and third agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burn_s <= '0;
         press_s <= '0;
         burn_ok <= 1'b0;
         press_ok <= 1'b0;
      end else begin
         burn_s <= {burn_s[1:0], burner_firing};
         press_s <= {press_s[1:0], pressure_ok};
         if (burn_s[1] == burn_s[2]) begin
            burn_ok <= burn_s[2];
         end
         if (press_s[1] == press_s[2]) begin
            press_ok <= press_s[2];
         end
      end
   end
   wire permit = burn_ok && press_ok && probe_alive && ctrl[CTRL_EN];

   // Seconds tick enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= '0;
         sec_tick <= 1'b0;
      end else begin
         sec_tick <= (tick_cnt == 25'(SEC_CYCLES - 1));
         tick_cnt <= (tick_cnt == 25'(SEC_CYCLES - 1)) ? '0 : tick_cnt + 25'd1;
      end
   end

   // One-second average of ten samples
   wire [19:0] sum_next = sec_sum + 20'(smp.ppm);
   wire sec_done = smp.valid && (sec_n == 4'd9);
   wire [15:0] sec_avg = 16'(sum_next / 20'd10);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_sum <= '0;
         sec_n <= '0;
      end else if (smp.valid) begin
         sec_sum <= sec_done ? '0 : sum_next;
         sec_n <= sec_done ? '0 : sec_n + 4'd1;
      end
   end

   // Rolling history of ten one-second averages
   always_ff @(posedge pclk) begin
      if (sec_done) begin
         hist[hist_ptr] <= sec_avg;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist_ptr <= '0;
         hist_sum <= '0;
         hist_full <= 1'b0;
         reading <= '0;
      end else if (sec_done) begin
         hist_ptr <= (hist_ptr == 4'd9) ? '0 : hist_ptr + 4'd1;
         hist_full <= hist_full || (hist_ptr == 4'd9);
         hist_sum <= hist_sum + 20'(sec_avg) - (hist_full ? 20'(hist[hist_ptr]) : 20'd0);
         reading <= 16'((hist_sum + 20'(sec_avg)
            - (hist_full ? 20'(hist[hist_ptr]) : 20'd0)) / 20'd10);
      end
   end

   wire above = reading > target;
   wire cal_req = (cal_phase != 2'd0);

   // Sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: if (permit || cal_req) next_state = above || cal_req ? ST_BLOW : ST_WAIT;
         ST_BLOW: if (sec_tick && sec_left <= 9'd1) next_state = ST_SETTLE;
         ST_SETTLE: if (sec_tick && sec_left <= 9'd1) next_state = ST_MEAS;
         ST_MEAS: if (sec_tick && sec_left <= 9'd1) begin
            if (cal_req) next_state = ST_CALHOLD;
            else next_state = above ? ST_BLOW : ST_WAIT;
         end
         ST_WAIT: if (sec_tick && sec_left <= 9'd1) next_state = ST_SAMPLE;
         ST_SAMPLE: if (sec_tick && sec_left <= 9'd1) begin
            next_state = above ? ST_BLOW : ST_WAIT;
         end
         ST_CALHOLD: if (!cal_req) next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
      if (!permit && !cal_req && state != ST_IDLE) next_state = ST_IDLE;
   end

   // State register and per-phase seconds counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         sec_left <= '0;
      end else begin
         state <= next_state;
         if (next_state != state) begin
            case (next_state)
               ST_BLOW: sec_left <= bdt;
               ST_SETTLE: sec_left <= 9'(SETTLE_S);
               ST_MEAS: sec_left <= 9'(MEASURE_S);
               ST_WAIT: sec_left <= sti;
               ST_SAMPLE: sec_left <= dst;
               ST_CALHOLD: sec_left <= 9'(CAL_WAIT_S);
               default: sec_left <= '0;
            endcase
         end else if (sec_tick && sec_left != 9'd0) begin
            sec_left <= sec_left - 9'd1;
         end
      end
   end

   // Valve and sampling solenoid open in blowdown and sample phases
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valve_open <= 1'b0;
      end else begin
         valve_open <= (next_state == ST_BLOW) || (next_state == ST_SAMPLE);
      end
   end

   // Calibration: 1 running sequence, 2 reference held
   wire auto_ready = (sec_left == 9'd0);
   wire cal_finish = run_key && (cal_phase == 2'd2) && (!ctrl[CTRL_AUTO] || auto_ready);
   wire [25:0] ref_ppm_calc = (26'(ref_cond) * 26'(mult)) >> 10;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cal_phase <= '0;
         ref_cond <= '0;
         ref_temp <= '0;
         ref_ppm <= '0;
         cal_done <= 1'b0;
      end else begin
         if (cal_key && cal_phase == 2'd0) begin
            cal_phase <= 2'd1;
            cal_done <= 1'b0;
         end else if (state == ST_MEAS && next_state == ST_CALHOLD) begin
            cal_phase <= 2'd2;
            ref_cond <= smp.cond;
            ref_temp <= probe.temp_c;
         end else if (cal_finish) begin
            cal_phase <= 2'd0;
            cal_done <= 1'b1;
            ref_ppm <= ctrl[CTRL_AUTO] ? 16'(ref_ppm_calc) : cal_ppm;
         end
      end
   end

   // Checks
   property p_blow_settle;
      @(posedge pclk) disable iff (!presetn)
      (state == ST_BLOW && next_state == ST_SETTLE) |=> sec_left == 9'(SETTLE_S);
   endproperty
   a_blow_settle: assert property (p_blow_settle) else $error("settle load");
   property p_meas_load;
      @(posedge pclk) disable iff (!presetn)
      (state == ST_SETTLE && next_state == ST_MEAS) |=> sec_left == 9'(MEASURE_S);
   endproperty
   a_meas_load: assert property (p_meas_load) else $error("measure load");
   property p_bdt_range;
      @(posedge pclk) disable iff (!presetn) bdt >= BDT_MIN && bdt <= BDT_MAX;
   endproperty
   a_bdt_range: assert property (p_bdt_range) else $error("bdt range");
   property p_valve;
      @(posedge pclk) disable iff (!presetn)
      valve_open |-> (state == ST_BLOW || state == ST_SAMPLE);
   endproperty
   a_valve: assert property (p_valve) else $error("valve state");
   property p_suspend;
      @(posedge pclk) disable iff (!presetn)
      (!permit && !cal_req && state != ST_IDLE) |=> state == ST_IDLE;
   endproperty
   a_suspend: assert property (p_suspend) else $error("no suspend");
   property p_remeasure;
      @(posedge pclk) disable iff (!presetn)
      (state == ST_MEAS && next_state == ST_BLOW) |=> sec_left == bdt;
   endproperty
   a_remeasure: assert property (p_remeasure) else $error("reblow");
   property p_interval;
      @(posedge pclk) disable iff (!presetn)
      (state != ST_WAIT && next_state == ST_WAIT) |=> sec_left == sti;
   endproperty
   a_interval: assert property (p_interval) else $error("interval");
   property p_sample_len;
      @(posedge pclk) disable iff (!presetn)
      (state == ST_WAIT && next_state == ST_SAMPLE) |=> sec_left == dst;
   endproperty
   a_sample_len: assert property (p_sample_len) else $error("sample len");
   c_blow: cover property (@(posedge pclk) state == ST_BLOW);
   c_sample: cover property (@(posedge pclk) state == ST_SAMPLE);
   c_cal: cover property (@(posedge pclk) cal_finish);
endmodule // tds_blowdown_sequencer

// File: bench/probe_model.sv
// Purpose: Stand-in for the conductivity probe and the top blowdown valve.
// Assumes: Probe words are taken on pclk.
// Notes: Net probe current is zero inside pulses, so conductivity reads zero.
`timescale 1ns/1ns
module probe_model
   import tds_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Device side
   input wire logic excite,
   input wire logic valve_open,
   input wire logic silent,
   // Probe side and valve record
   output probe_in_t probe,
   output logic probe_alive,
   output logic [7:0] n_open
);
   logic excite_d = 1'b0;
   logic valve_d = 1'b0;
   logic [7:0] opens = 8'h00;
   logic [15:0] noise = 16'h5A5A;
   // Current equals offset during a pulse; drifting noise between pulses
   assign probe.pol_ua = 16'sh0064;
   assign probe.current_ua = (excite | excite_d) ? 16'h0064 : noise;
   assign probe.temp_c = 12'sh019;
   assign probe_alive = !silent;
   assign n_open = opens;
   // Noise pattern and count of valve openings
   always_ff @(posedge pclk) begin
      excite_d <= excite;
      valve_d <= valve_open;
      noise <= noise + 16'h1235;
      if (valve_open && !valve_d) begin
         opens <= opens + 8'h01;
      end
   end
endmodule // probe_model

// File: bench/tb_top.sv
// Purpose: Self-checking bench for the dissolved-solids sequencer.
// Assumes: One second shortened to S cycles; probe gives zero conductivity.
// Notes: Every wait is bounded; timeouts count as mismatches.
`timescale 1ns/1ns
module tb_top
   import tds_pkg::*;
;
   localparam int S = 100;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   probe_in_t probe;
   logic probe_alive;
   logic burner_firing = 1'b1;
   logic pressure_ok = 1'b1;
   logic silent = 1'b0;
   logic excite;
   logic valve_open;
   logic [7:0] n_open;
   logic [31:0] q;
   logic e;
   int n;
   int n_fail = 0;
   int num_checks = 0;

   // Clock
   always #20 pclk = ~pclk;

   tds_blowdown_sequencer #(.SEC_CYCLES(S)) i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .probe(probe),
      .probe_alive(probe_alive), .burner_firing(burner_firing),
      .pressure_ok(pressure_ok), .excite(excite), .valve_open(valve_open));

   probe_model i_probe (.pclk(pclk), .excite(excite), .valve_open(valve_open),
      .silent(silent), .probe(probe), .probe_alive(probe_alive), .n_open(n_open));

   // Verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; answer taken at the edge where pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_fail++;
         $display("Error %0t: bus answer timed out", $time);
         end_sim();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   task automatic st(input seq_state_t s);
      rd(OFS_STATUS);
      check({29'h0, q[2:0]}, {29'h0, s});
   endtask

   // Wait for the valve level, n counts the cycles spent
   task automatic wait_valve(input logic lv, input int mx);
      n = 0;
      while (valve_open !== lv) begin
         @(negedge pclk);
         n++;
         if (n > mx) begin
            n_fail++;
            $display("Error %0t: valve wait timed out", $time);
            end_sim();
         end
      end
   endtask

   task automatic t_excite();
      n = 0;
      while (excite !== 1'b1 && n < 20) begin
         @(negedge pclk);
         n++;
      end
      if (excite !== 1'b1) begin
         n_fail++;
         $display("Error %0t: no excitation pulse", $time);
         end_sim();
      end
      n = 0;
      while (excite === 1'b1 && n < 8000) begin
         @(negedge pclk);
         n++;
      end
      check(32'(n), 32'(PULSE_CYC));
      check({31'h0, excite}, 32'h0000_0000);
   endtask

   task automatic t_regs();
      logic [7:0] ca [8] = '{OFS_BDT, OFS_BDT, OFS_STI, OFS_STI, OFS_DST, OFS_DST,
         OFS_MULT, OFS_MULT};
      int cw [8] = '{1, 400, 10, 999, 1, 20, 600, 900};
      int ce [8] = '{5, 300, 60, 300, 3, 10, 667, 767};
      rd(OFS_TARGET);
      check(q, {16'h0, TARGET_RST});
      rd(OFS_BDT);
      check(q, {23'h0, BDT_RST});
      rd(OFS_STI);
      check(q, {23'h0, STI_RST});
      rd(OFS_DST);
      check(q, {23'h0, DST_RST});
      rd(OFS_MULT);
      check(q, {22'h0, MULT_NOM});
      st(ST_IDLE);
      foreach (ca[i]) begin
         wr(ca[i], 32'(cw[i]));
         rd(ca[i]);
         check(q, 32'(ce[i]));
      end
      wr(OFS_BDT, 32'h0000_0005);
      wr(OFS_STI, 32'h0000_003C);
      wr(OFS_DST, 32'h0000_0003);
   endtask

   task automatic t_unmapped();
      wr(8'h2C, 32'h0000_00FF);
      check({31'h0, e}, 32'h0000_0001);
      rd(8'h05);
      check({31'h0, e}, 32'h0000_0001);
      check(q, 32'h0000_0000);
   endtask

   task automatic t_periodic();
      wr(OFS_CTRL, 32'h0000_0001);
      repeat (10) @(posedge pclk);
      st(ST_WAIT);
      wait_valve(1'b1, 62 * S);
      check(32'(n >= 58 * S), 32'h0000_0001);
      st(ST_SAMPLE);
      wait_valve(1'b0, 12 * S);
      check(32'(n >= 2 * S - 10 && n <= 3 * S + 10), 32'h0000_0001);
      repeat (10) @(posedge pclk);
      st(ST_WAIT);
      // Remove burner, pressure and probe permits in turn
      for (int k = 0; k < 3; k++) begin
         burner_firing <= (k != 0);
         pressure_ok <= (k != 1);
         silent <= (k == 2);
         repeat (10) @(posedge pclk);
         st(ST_IDLE);
         burner_firing <= 1'b1;
         pressure_ok <= 1'b1;
         silent <= 1'b0;
         repeat (10) @(posedge pclk);
         st(ST_WAIT);
      end
      wr(OFS_CTRL, 32'h0000_0000);
   endtask

   // Settlement, measurement and hold after a calibration blowdown
   task automatic cal_tail();
      st(ST_SETTLE);
      repeat (4 * S - 20) @(posedge pclk);
      st(ST_SETTLE);
      repeat (S + 20) @(posedge pclk);
      st(ST_MEAS);
      repeat (3 * S - 50) @(posedge pclk);
      st(ST_MEAS);
      check({31'h0, q[3]}, 32'h0000_0000);
      repeat (2 * S + 60) @(posedge pclk);
      st(ST_CALHOLD);
   endtask

   task automatic t_cal_user();
      wr(OFS_CTRL, 32'h0000_0002);
      wait_valve(1'b1, 2 * S);
      st(ST_BLOW);
      wait_valve(1'b0, 7 * S);
      check(32'(n >= 4 * S - 10 && n <= 5 * S + 10), 32'h0000_0001);
      cal_tail();
      wr(OFS_CALPPM, 32'h0000_04D2);
      wr(OFS_CTRL, 32'h0000_0004);
      rd(OFS_REFPPM);
      check(q, 32'h0000_04D2);
      st(ST_IDLE);
      check({31'h0, q[4]}, 32'h0000_0001);
      check({24'h0, n_open}, 32'h0000_0002);
   endtask

   // Zero conductivity from the probe gives a computed reference of zero
   task automatic t_cal_auto();
      wr(OFS_CTRL, 32'h0000_000A);
      wait_valve(1'b1, 2 * S);
      wait_valve(1'b0, 7 * S);
      cal_tail();
      wr(OFS_CTRL, 32'h0000_000C);
      rd(OFS_REFPPM);
      check(q, 32'h0000_04D2);
      st(ST_CALHOLD);
      check({31'h0, q[4]}, 32'h0000_0000);
      repeat (61 * S) @(posedge pclk);
      wr(OFS_CTRL, 32'h0000_000C);
      rd(OFS_REFPPM);
      check(q, 32'h0000_0000);
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_excite();
      t_regs();
      t_unmapped();
      t_periodic();
      t_cal_user();
      t_cal_auto();
      end_sim();
   end
endmodule // tb_top
